// file: rtl/drc_pkg.sv
// constants for the detector read-out controller
package drc_pkg;
    // register byte offsets
    localparam logic [7:0] DRC_LAUNCH_OFS = 8'h00;
    localparam logic [7:0] DRC_HDROFF_OFS = 8'h04;
    localparam logic [7:0] DRC_TRAILER_OFS = 8'h08;
    localparam logic [7:0] DRC_MODE_OFS = 8'h0c;
    localparam logic [7:0] DRC_COMMAND_OFS = 8'h10;
    localparam logic [7:0] DRC_STATUS_OFS = 8'h14;
    // command register bit positions
    localparam int DRC_CMD_SOFT_BIT = 0;
    localparam int DRC_CMD_HARD_BIT = 1;
    localparam int DRC_CMD_MON_BIT = 2;
    // mode field positions
    localparam int DRC_MODE_SIDE_BIT = 0;
    localparam int DRC_MODE_BYPASS_BIT = 1;
    // values after power-up or hard reset
    localparam logic [7:0] DRC_TIMER_RESET = 8'hff;
    localparam logic [1:0] DRC_MODE_RESET = 2'h0;
    // frame fields
    localparam logic [5:0] DRC_PHYS_PREAMBLE = 6'h3a;
    localparam logic [5:0] DRC_MON_PREAMBLE = 6'h3b;
    localparam logic [1:0] DRC_ALARM_PAYLOAD = 2'h0;
    localparam logic [1:0] DRC_FRAME_MARK = 2'h3;
    // bit counts of the shared shifter and the monitor channel count
    localparam logic [4:0] DRC_HEADER_BITS = 5'h12;
    localparam logic [4:0] DRC_PREAMBLE_BITS = 5'h06;
    localparam logic [4:0] DRC_ERROR_BITS = 5'h08;
    localparam logic [4:0] DRC_MON_WORD_BITS = 5'h0c;
    localparam logic [3:0] DRC_MON_CHANNELS = 4'h8;
    localparam logic [1:0] DRC_DRAIN_LAST = 2'h2; // chain bits still due after its token, less one
    // controller states, gray along the usual path from idle up to the trailer
    typedef enum logic [3:0] {
        DRC_IDLE = 4'h0,
        DRC_LAUNCH = 4'h1,
        DRC_HEADER = 4'h3,
        DRC_CHAIN = 4'h2,
        DRC_TRAILER = 4'h6,
        DRC_ERROR = 4'h7,
        DRC_MON_PRE = 4'h5,
        DRC_MON_WAIT = 4'h4
    } drc_state_t;
    // monitor unit states
    typedef enum logic [1:0] {
        DRC_M_IDLE = 2'h0,
        DRC_M_CONV = 2'h1,
        DRC_M_REQ = 2'h3,
        DRC_M_SHIFT = 2'h2
    } drc_mon_state_t;
endpackage

// file: rtl/drc_readout.sv
// read-out controller and monitor unit with a shared serialiser
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module drc_readout
    import drc_pkg::*;
#(
    parameter int TIMER_W = 8,
    parameter int HEADER_W = 12
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    // reset and monitor commands from the decoder
    input wire logic soft_reset_in,
    input wire logic hard_reset_in,
    input wire logic monitor_start,
    // trigger fifo
    input wire logic trigger_queue_empty_n,
    input wire logic fifo_overflow,
    input wire logic [HEADER_W-1:0] fifo_head,
    output logic fifo_unload,
    // front-end chain
    input wire logic chain_data_in_a,
    input wire logic chain_data_in_b,
    input wire logic chain_data_in_bypass,
    input wire logic chain_token_in_a,
    input wire logic chain_token_in_b,
    input wire logic chain_token_in_bypass,
    output logic chain_data_out_a,
    output logic chain_data_out_b,
    output logic chain_data_out_bypass,
    output logic chain_token_out_a,
    output logic chain_token_out_b,
    output logic chain_token_out_bypass,
    // monitor channel front end
    input wire logic [7:0] monitor_sample,
    output logic [2:0] monitor_channel,
    output logic monitor_convert,
    // serial link
    output logic link
);
    drc_state_t state, next_state;
    drc_mon_state_t mstate, next_mstate;
    logic [TIMER_W-1:0] launch_time, header_offset, trailer_len;
    logic [1:0] mode, drain_cnt;
    logic [TIMER_W-1:0] launch_cnt, hoc_cnt, trc_cnt;
    logic hoc_active, tok_seen, alarm, alarm_sent, monitor_request, next_link;
    logic [17:0] psc;
    logic [4:0] psc_cnt, hdr_cycles;
    logic [7:0] mon_mem [0:7];
    logic [3:0] mon_idx;
    logic mon_phase;
    logic ret_data_a, ret_data_b, ret_data_bp, ret_tok_a, ret_tok_b, ret_tok_bp;

    // register decode and internal resets
    wire wr_launch = reg_write && reg_addr == DRC_LAUNCH_OFS;
    wire wr_hdroff = reg_write && reg_addr == DRC_HDROFF_OFS;
    wire wr_trailer = reg_write && reg_addr == DRC_TRAILER_OFS;
    wire bypass_select_latch = reg_write && reg_addr == DRC_MODE_OFS;
    wire wr_command = reg_write && reg_addr == DRC_COMMAND_OFS;
    wire hard_reset = hard_reset_in || (wr_command && reg_wdata[DRC_CMD_HARD_BIT]);
    wire soft_reset = soft_reset_in || (wr_command && reg_wdata[DRC_CMD_SOFT_BIT]);
    wire any_reset = rst || hard_reset || soft_reset;
    wire mon_cmd = monitor_start || (wr_command && reg_wdata[DRC_CMD_MON_BIT]);

    // input selection from the latched mode
    wire sel_data = mode[DRC_MODE_BYPASS_BIT] ? ret_data_bp :
                    (mode[DRC_MODE_SIDE_BIT] ? ret_data_b : ret_data_a);
    wire sel_token = mode[DRC_MODE_BYPASS_BIT] ? ret_tok_bp :
                     (mode[DRC_MODE_SIDE_BIT] ? ret_tok_b : ret_tok_a);

    // compare signals of the timing counters
    wire fifo_equal_ptrs = trigger_queue_empty_n;
    wire launch_count_match = launch_cnt == launch_time;
    wire header_offset_match = hoc_active && hoc_cnt == header_offset;
    wire trailer_count_match = trc_cnt == trailer_len;
    wire psc_done_hdr = psc_cnt == DRC_HEADER_BITS - 5'h01;
    wire psc_done_pre = psc_cnt == DRC_PREAMBLE_BITS - 5'h01;
    wire psc_done_err = psc_cnt == DRC_ERROR_BITS - 5'h01;
    wire psc_done_mon = psc_cnt == DRC_MON_WORD_BITS - 5'h01;
    wire last_mon_word = mon_idx == DRC_MON_CHANNELS - 4'h1;

    // serialiser load strobes, never both at once
    wire load_ctrl = (state == DRC_LAUNCH && launch_count_match) ||
                     (state == DRC_IDLE && fifo_equal_ptrs && alarm && !alarm_sent) ||
                     (state == DRC_IDLE && fifo_equal_ptrs && !(alarm && !alarm_sent) && monitor_request);
    wire monitor_token_send = state == DRC_MON_PRE && psc_done_pre;
    wire load_mon = (mstate == DRC_M_REQ && monitor_token_send) ||
                    (mstate == DRC_M_SHIFT && psc_done_mon && !last_mon_word);
    wire monitor_token_return = mstate == DRC_M_SHIFT && psc_done_mon && last_mon_word;
    wire ctrl_shift = state == DRC_HEADER || state == DRC_ERROR || state == DRC_MON_PRE;

    // controller next state
    always_comb begin
        next_state = state;
        case (state)
            DRC_IDLE: begin
                if (!fifo_equal_ptrs) begin
                    next_state = DRC_LAUNCH;
                end else if (alarm && !alarm_sent) begin
                    next_state = DRC_ERROR;
                end else if (monitor_request && mstate == DRC_M_REQ) begin
                    next_state = DRC_MON_PRE;
                end
            end
            DRC_LAUNCH: begin
                if (launch_count_match) begin
                    next_state = DRC_HEADER;
                end
            end
            DRC_HEADER: begin
                if (psc_done_hdr) begin
                    next_state = DRC_CHAIN;
                end
            end
            DRC_CHAIN: begin
                if (tok_seen && drain_cnt == DRC_DRAIN_LAST) begin
                    next_state = DRC_TRAILER;
                end
            end
            DRC_TRAILER: begin
                if (trailer_count_match) begin
                    next_state = DRC_IDLE;
                end
            end
            DRC_ERROR: begin
                if (psc_done_err) begin
                    next_state = DRC_TRAILER;
                end
            end
            DRC_MON_PRE: begin
                if (psc_done_pre) begin
                    next_state = DRC_MON_WAIT;
                end
            end
            DRC_MON_WAIT: begin
                if (monitor_token_return) begin
                    next_state = DRC_TRAILER;
                end
            end
            default: next_state = DRC_IDLE;
        endcase
    end

    // monitor unit next state
    always_comb begin
        next_mstate = mstate;
        case (mstate)
            DRC_M_IDLE: begin
                if (mon_cmd) begin
                    next_mstate = DRC_M_CONV;
                end
            end
            DRC_M_CONV: begin
                if (mon_phase && last_mon_word) begin
                    next_mstate = DRC_M_REQ;
                end
            end
            DRC_M_REQ: begin
                if (monitor_token_send) begin
                    next_mstate = DRC_M_SHIFT;
                end
            end
            DRC_M_SHIFT: begin
                if (monitor_token_return) begin
                    next_mstate = DRC_M_IDLE;
                end
            end
            default: next_mstate = DRC_M_IDLE;
        endcase
    end

    // state registers, back to idle on any reset
    always_ff @(posedge clock) begin
        if (any_reset) begin
            state <= DRC_IDLE;
            mstate <= DRC_M_IDLE;
        end else begin
            state <= next_state;
            mstate <= next_mstate;
        end
    end

    // timing and mode registers, timers all ones and mode zero after power-up
    always_ff @(posedge clock) begin
        if (rst || hard_reset) begin
            launch_time <= TIMER_W'(DRC_TIMER_RESET);
            header_offset <= TIMER_W'(DRC_TIMER_RESET);
            trailer_len <= TIMER_W'(DRC_TIMER_RESET);
            mode <= DRC_MODE_RESET;
        end else begin
            if (wr_launch) launch_time <= reg_wdata[TIMER_W-1:0];
            if (wr_hdroff) header_offset <= reg_wdata[TIMER_W-1:0];
            if (wr_trailer) trailer_len <= reg_wdata[TIMER_W-1:0];
            if (bypass_select_latch) mode <= reg_wdata[1:0];
        end
    end

    // launch, header offset and trailer counters
    always_ff @(posedge clock) begin
        if (any_reset || state != DRC_LAUNCH) launch_cnt <= '0;
        else launch_cnt <= launch_cnt + 1'b1;
        if (any_reset || header_offset_match) hoc_active <= 1'b0;
        else if (state == DRC_LAUNCH && launch_count_match) hoc_active <= 1'b1;
        if (any_reset || !hoc_active) hoc_cnt <= '0;
        else hoc_cnt <= hoc_cnt + 1'b1;
        if (any_reset || state != DRC_TRAILER) trc_cnt <= '0;
        else trc_cnt <= trc_cnt + 1'b1;
        if (any_reset || state != DRC_CHAIN || !tok_seen) drain_cnt <= '0;
        else drain_cnt <= drain_cnt + 2'h1;
        if (any_reset || state != DRC_HEADER) hdr_cycles <= '0;
        else hdr_cycles <= hdr_cycles + 5'h01;
    end

    // token back may arrive while the header is still going out
    always_ff @(posedge clock) begin
        if (any_reset || state == DRC_IDLE) tok_seen <= 1'b0;
        else if ((state == DRC_HEADER || state == DRC_CHAIN) && sel_token) tok_seen <= 1'b1;
    end

    // alarm flag, the overflow wins over a soft or hard reset clear, rst wins over the overflow
    always_ff @(posedge clock) begin
        if (fifo_overflow && !rst) alarm <= 1'b1;
        else if (rst || hard_reset || soft_reset) alarm <= 1'b0;
        if (rst || hard_reset || soft_reset) alarm_sent <= 1'b0;
        else if (state == DRC_ERROR) alarm_sent <= 1'b1;
    end

    // shared parallel to serial converter, msb first
    always_ff @(posedge clock) begin
        if (any_reset) begin
            psc <= '0;
            psc_cnt <= '0;
        end else if (load_ctrl) begin
            psc_cnt <= '0;
            if (state == DRC_LAUNCH) psc <= {DRC_PHYS_PREAMBLE, fifo_head};
            else if (alarm && !alarm_sent) psc <= {DRC_MON_PREAMBLE, DRC_ALARM_PAYLOAD, 10'h000};
            else psc <= {DRC_MON_PREAMBLE, 12'h000};
        end else if (load_mon) begin
            psc_cnt <= '0;
            psc <= {DRC_FRAME_MARK, mon_mem[mon_idx[2:0] + (mstate == DRC_M_SHIFT ? 3'h1 : 3'h0)],
                    DRC_FRAME_MARK, 6'h00};
        end else if (ctrl_shift || mstate == DRC_M_SHIFT) begin
            psc <= {psc[16:0], 1'b0};
            psc_cnt <= psc_cnt + 5'h01;
        end
    end

    // monitor conversion and memory, channels in fixed order
    always_ff @(posedge clock) begin
        if (any_reset) begin
            mon_idx <= '0;
            mon_phase <= 1'b0;
            monitor_request <= 1'b0;
            monitor_convert <= 1'b0;
            monitor_channel <= '0;
        end else begin
            monitor_convert <= next_mstate == DRC_M_CONV && (mstate != DRC_M_CONV || mon_phase);
            if (mstate == DRC_M_CONV) begin
                mon_phase <= !mon_phase;
                if (mon_phase) begin
                    mon_mem[mon_idx[2:0]] <= monitor_sample;
                    mon_idx <= last_mon_word ? 4'h0 : mon_idx + 4'h1;
                    monitor_channel <= mon_idx[2:0] + 3'h1;
                end
            end else if (load_mon && mstate == DRC_M_SHIFT) begin
                mon_idx <= mon_idx + 4'h1;
            end else if (mstate == DRC_M_IDLE) begin
                mon_idx <= '0;
                monitor_channel <= '0;
            end
            if (mstate == DRC_M_CONV && mon_phase && last_mon_word) monitor_request <= 1'b1;
            else if (monitor_token_send) monitor_request <= 1'b0;
        end
    end

    // one flop retiming of every chain input
    always_ff @(posedge clock) begin
        ret_data_a <= chain_data_in_a;
        ret_data_b <= chain_data_in_b;
        ret_data_bp <= chain_data_in_bypass;
        ret_tok_a <= chain_token_in_a;
        ret_tok_b <= chain_token_in_b;
        ret_tok_bp <= chain_token_in_bypass;
    end

    // link bit for the current frame phase
    always_comb begin
        case (state)
            DRC_HEADER, DRC_CHAIN: next_link = sel_data;
            DRC_TRAILER: next_link = trc_cnt == '0;
            DRC_ERROR, DRC_MON_PRE: next_link = psc[17];
            DRC_MON_WAIT: next_link = mstate == DRC_M_SHIFT && psc[17];
            default: next_link = 1'b0;
        endcase
    end

    // registered outputs, all driven from reset on
    always_ff @(posedge clock) begin
        if (rst) begin
            link <= 1'b0;
            chain_data_out_a <= 1'b0;
            chain_data_out_b <= 1'b0;
            chain_data_out_bypass <= 1'b0;
            chain_token_out_a <= 1'b0;
            chain_token_out_b <= 1'b0;
            chain_token_out_bypass <= 1'b0;
            fifo_unload <= 1'b0;
        end else begin
            link <= next_link;
            chain_data_out_a <= state == DRC_HEADER && psc[17];
            chain_data_out_b <= state == DRC_HEADER && psc[17];
            chain_data_out_bypass <= state == DRC_HEADER && psc[17];
            chain_token_out_a <= header_offset_match;
            chain_token_out_b <= header_offset_match;
            chain_token_out_bypass <= header_offset_match;
            fifo_unload <= state == DRC_LAUNCH && launch_count_match;
        end
    end

    // register read, one cycle later, zero elsewhere
    wire [15:0] status_word = {8'h00, mstate, state, monitor_request, alarm};
    always_ff @(posedge clock) begin
        if (rst || !reg_read) reg_rdata <= '0;
        else if (reg_addr == DRC_LAUNCH_OFS) reg_rdata <= 16'(launch_time);
        else if (reg_addr == DRC_HDROFF_OFS) reg_rdata <= 16'(header_offset);
        else if (reg_addr == DRC_TRAILER_OFS) reg_rdata <= 16'(trailer_len);
        else if (reg_addr == DRC_MODE_OFS) reg_rdata <= {14'h0000, mode};
        else if (reg_addr == DRC_STATUS_OFS) reg_rdata <= status_word;
        else reg_rdata <= '0;
    end

    // checks on the guarded behaviour
    a_priority_fifo: assert property (@(posedge clock) disable iff (any_reset)
        state == DRC_IDLE && !fifo_equal_ptrs |=> state == DRC_LAUNCH)
        else $error("waiting fifo entry not served first");
    a_launch_wait: assert property (@(posedge clock) disable iff (any_reset)
        state == DRC_LAUNCH && !launch_count_match |=> state == DRC_LAUNCH)
        else $error("header left before launch compare");
    a_header_len: assert property (@(posedge clock) disable iff (any_reset)
        state == DRC_HEADER |=> (state == DRC_HEADER) == ($past(hdr_cycles) != DRC_HEADER_BITS - 5'h01))
        else $error("physics header not eighteen bits");
    a_token_launch: assert property (@(posedge clock) disable iff (any_reset)
        header_offset_match |=> chain_token_out_a && chain_token_out_b && chain_token_out_bypass)
        else $error("token not launched on offset compare");
    a_trailer_one: assert property (@(posedge clock) disable iff (any_reset)
        $rose(state == DRC_TRAILER) |=> link)
        else $error("trailer does not begin with one");
    a_mon_token: assert property (@(posedge clock) disable iff (any_reset)
        monitor_token_send |=> state == DRC_MON_WAIT && mstate == DRC_M_SHIFT)
        else $error("monitor token not taken");
    a_mon_return: assert property (@(posedge clock) disable iff (any_reset)
        $rose(mstate == DRC_M_SHIFT) |-> ##[1:100] monitor_token_return)
        else $error("monitor token not returned");
    a_alarm_hold: assert property (@(posedge clock) disable iff (rst)
        alarm && !hard_reset && !soft_reset |=> alarm)
        else $error("alarm cleared without reset");
    a_load_excl: assert property (@(posedge clock) disable iff (any_reset)
        !(load_ctrl && load_mon))
        else $error("both serialiser loads active");
    a_one_frame: assert property (@(posedge clock) disable iff (any_reset)
        mstate == DRC_M_SHIFT |-> state == DRC_MON_WAIT)
        else $error("monitor shifting outside its frame");
    a_mon_request: assert property (@(posedge clock) disable iff (any_reset)
        $rose(monitor_request) |-> $past(mstate) == DRC_M_CONV && mon_idx == 4'h0)
        else $error("request before all channels stored");
endmodule
`default_nettype wire

// file: testbench/drc_chip_model.sv
// front-end chip stand-in on the token chain
`timescale 1ns/1ps
`default_nettype none
module drc_chip_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // chain side
    input wire logic loaded,
    input wire logic data_in,
    input wire logic token_in,
    output logic data_out,
    output logic token_out
);
    logic [3:0] t;
    wire logic [7:0] buf_word = 8'h96;
    // one-bit pass path, buffer unload three cycles after token
    always_ff @(posedge clock) begin
        if (rst) begin
            t <= 4'h0;
            data_out <= 1'b0;
            token_out <= 1'b0;
        end else begin
            if (token_in && loaded) begin
                t <= 4'h1;
            end else if (t != 4'h0) begin
                t <= (t == 4'ha) ? 4'h0 : t + 4'h1;
            end
            data_out <= (t >= 4'h3) ? buf_word[4'ha - t] : data_in;
            token_out <= loaded ? (t == 4'h7) : token_in;
        end
    end
endmodule
`default_nettype wire

// file: testbench/tb_detector_readout_controller.sv
// self-checking bench for the read-out controller
`timescale 1ns/1ps
`default_nettype none
module tb_detector_readout_controller;
    import drc_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic soft_reset_in = 1'b0;
    logic hard_reset_in = 1'b0;
    logic fifo_overflow = 1'b0;
    logic push = 1'b0;
    logic [1:0] push_n = 2'h0;
    logic [1:0] qcnt = 2'h0;
    logic [1:0] sel = 2'h0;
    logic loaded = 1'b0;
    logic toggle = 1'b0;
    int unloads = 0;
    int convs = 0;
    int fails = 0;
    int cmp_count = 0;
    logic [15:0] reg_rdata;
    logic [2:0] monitor_channel;
    logic fifo_unload, m_data, m_tok, mon_conv, link, do_a, do_b, do_p, to_a, to_b, to_p;
    wire logic [7:0] monitor_sample = {monitor_channel, 5'h0b};
    wire logic trigger_queue_empty_n = (qcnt == 2'h0);
    // unselected chain inputs carry a changing pattern
    wire logic di_a = (sel == 2'h0) ? m_data : toggle;
    wire logic di_b = (sel == 2'h1) ? m_data : toggle;
    wire logic di_p = (sel == 2'h2) ? m_data : toggle;
    wire logic ti_a = (sel == 2'h0) ? m_tok : toggle;
    wire logic ti_b = (sel == 2'h1) ? m_tok : toggle;
    wire logic ti_p = (sel == 2'h2) ? m_tok : toggle;

    initial begin
        forever #50 clock = ~clock;
    end

    // trigger fifo stand-in
    always_ff @(posedge clock) begin
        toggle <= ~toggle;
        if (push) begin
            qcnt <= push_n;
        end else if (soft_reset_in || hard_reset_in) begin
            qcnt <= 2'h0;
        end else if (fifo_unload && qcnt != 2'h0) begin
            qcnt <= qcnt - 2'h1;
        end
        if (fifo_unload) begin
            unloads <= unloads + 1;
        end
        if (mon_conv) begin
            convs <= convs + 1;
        end
    end

    drc_readout i_drc_readout (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .soft_reset_in(soft_reset_in),
        .hard_reset_in(hard_reset_in), .monitor_start(1'b0), .trigger_queue_empty_n(trigger_queue_empty_n),
        .fifo_overflow(fifo_overflow), .fifo_head(12'hc35), .fifo_unload(fifo_unload),
        .chain_data_in_a(di_a), .chain_data_in_b(di_b), .chain_data_in_bypass(di_p),
        .chain_token_in_a(ti_a), .chain_token_in_b(ti_b), .chain_token_in_bypass(ti_p),
        .chain_data_out_a(do_a), .chain_data_out_b(do_b), .chain_data_out_bypass(do_p),
        .chain_token_out_a(to_a), .chain_token_out_b(to_b), .chain_token_out_bypass(to_p),
        .monitor_sample(monitor_sample), .monitor_channel(monitor_channel), .monitor_convert(mon_conv),
        .link(link));

    drc_chip_model i_drc_chip_model (.clock(clock), .rst(rst), .loaded(loaded),
        .data_in(sel == 2'h2 ? do_p : (sel == 2'h1 ? do_b : do_a)),
        .token_in(sel == 2'h2 ? to_p : (sel == 2'h1 ? to_b : to_a)), .data_out(m_data), .token_out(m_tok));

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        d = reg_rdata;
    endtask

    // next link word: waits for its leading one, then n-1 more bits
    task automatic grab(input int n, output logic [17:0] v);
        int k;
        k = 0;
        do begin
            @(negedge clock);
            k++;
        end while (link !== 1'b1 && k < 600);
        if (k >= 600) begin
            fails++;
            summarize();
        end
        v = 18'h1;
        for (int i = 1; i < n; i++) begin
            @(negedge clock);
            v = {v[16:0], link};
        end
    endtask

    task automatic wait_idle();
        logic [15:0] d;
        int k;
        k = 0;
        do begin
            reg_rd(DRC_STATUS_OFS, d);
            k++;
        end while ((d[7:2] !== 6'h0 || qcnt != 2'h0) && k < 300);
        if (k >= 300) begin
            fails++;
            summarize();
        end
    endtask

    task automatic t_regs();
        logic [15:0] d;
        reg_rd(DRC_LAUNCH_OFS, d);
        chk(18'(d), 18'h000ff);
        reg_rd(DRC_MODE_OFS, d);
        chk(18'(d), 18'h0);
        reg_rd(8'h18, d);
        chk(18'(d), 18'h0);
        reg_wr(DRC_LAUNCH_OFS, 16'h0002);
        reg_wr(DRC_HDROFF_OFS, 16'h0010);
        reg_wr(DRC_TRAILER_OFS, 16'h0003);
        reg_rd(DRC_LAUNCH_OFS, d);
        chk(18'(d), 18'h00002);
    endtask

    task automatic t_phys(input logic [1:0] mode, input logic [1:0] s, input logic ld);
        logic [17:0] v;
        int u0;
        reg_wr(DRC_MODE_OFS, {14'h0, mode});
        sel <= s;
        loaded <= ld;
        u0 = unloads;
        push_n <= 2'h2;
        push <= 1'b1;
        @(posedge clock);
        push <= 1'b0;
        grab(18, v);
        chk(v, {DRC_PHYS_PREAMBLE, 12'hc35});
        if (ld) begin
            grab(8, v);
            chk(v, 18'h96);
        end
        wait_idle();
        chk(18'(unloads - u0), 18'h2);
    endtask

    task automatic t_alarm();
        logic [17:0] v;
        logic [15:0] d;
        @(posedge clock);
        push_n <= 2'h1;
        push <= 1'b1;
        fifo_overflow <= 1'b1;
        @(posedge clock);
        push <= 1'b0;
        fifo_overflow <= 1'b0;
        grab(18, v);
        chk(v, {DRC_PHYS_PREAMBLE, 12'hc35});
        grab(1, v);
        chk(v, 18'h1);
        grab(8, v);
        chk(v, {10'h0, DRC_MON_PREAMBLE, DRC_ALARM_PAYLOAD});
        reg_rd(DRC_STATUS_OFS, d);
        chk(18'(d[0]), 18'h1);
        soft_reset_in <= 1'b1;
        @(posedge clock);
        soft_reset_in <= 1'b0;
        reg_rd(DRC_STATUS_OFS, d);
        chk(18'(d[7:0]), 18'h0);
    endtask

    task automatic t_mon();
        logic [17:0] v;
        int c0;
        c0 = convs;
        reg_wr(DRC_COMMAND_OFS, 16'h0004);
        grab(6, v);
        chk(v, 18'(DRC_MON_PREAMBLE));
        for (int k = 0; k < 8; k++) begin
            grab(12, v);
            chk(v, {6'h0, 2'h3, 3'(k), 5'h0b, 2'h3});
        end
        wait_idle();
        chk(18'(convs - c0), 18'h8);
    endtask

    task automatic t_hard();
        logic [15:0] d;
        @(posedge clock);
        hard_reset_in <= 1'b1;
        @(posedge clock);
        hard_reset_in <= 1'b0;
        reg_rd(DRC_LAUNCH_OFS, d);
        chk(18'(d), 18'h000ff);
        reg_rd(DRC_MODE_OFS, d);
        chk(18'(d), 18'h0);
    endtask

    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_phys(2'h0, 2'h0, 1'b0);
        t_phys(2'h1, 2'h1, 1'b1);
        t_phys(2'h2, 2'h2, 1'b0);
        t_alarm();
        t_mon();
        t_hard();
        summarize();
    end
endmodule
`default_nettype wire
